// [include/ceoi_pkg.sv]
`default_nettype none
package ceoi_pkg;
	// system register write encodings (coproc 15, opc1 0)
	localparam logic [3:0] CP_COPROC    = 4'hf;
	localparam logic [2:0] CP_OPC1      = 3'h0;
	localparam logic [3:0] CP_CRN       = 4'hc;
	localparam logic [3:0] CRM_DEACT    = 4'hb;
	localparam logic [3:0] CRM_EOI0     = 4'h8;
	localparam logic [3:0] CRM_EOI1     = 4'hc;
	localparam logic [2:0] OPC2_WRITE   = 3'h1;
	// identifier field
	localparam int         ID_LSB       = 0;
	localparam int         ID_W_FULL    = 24;
	localparam int         ID_W_SHORT   = 16;
	localparam int         RES_TOP_LSB  = 24;
	// exception levels
	localparam logic [1:0] EL_0         = 2'h0;
	localparam logic [1:0] EL_1         = 2'h1;
	localparam logic [1:0] EL_2         = 2'h2;
	localparam logic [1:0] EL_3         = 2'h3;

	typedef enum logic [2:0] {
		CEOI_TGT_NONE  = 3'h0,
		CEOI_TGT_DEACT = 3'h1,
		CEOI_TGT_EOI0  = 3'h2,
		CEOI_TGT_EOI1  = 3'h3
	} ceoi_tgt_t;

	typedef enum logic [2:0] {
		CEOI_OUT_DONE  = 3'h0,
		CEOI_OUT_VIRT  = 3'h1,
		CEOI_OUT_TRAP2 = 3'h2,
		CEOI_OUT_TRAP3 = 3'h3,
		CEOI_OUT_UNDEF = 3'h4,
		CEOI_OUT_IGN   = 3'h5
	} ceoi_out_t;
endpackage : ceoi_pkg
`default_nettype wire

// [include/ceoi_req_if.sv]
`timescale 1ns/1ns
`default_nettype none
// decoded write request between the decoder and the checking core
interface ceoi_req_if;
	logic                  valid;
	ceoi_pkg::ceoi_tgt_t   tgt;
	logic [23:0]           interrupt_identifier;
	modport dec (output valid, output tgt, output interrupt_identifier);
	modport core (input valid, input tgt, input interrupt_identifier);
endinterface : ceoi_req_if
`default_nettype wire

// [core/ceoi_decode.sv]
`timescale 1ns/1ns
`default_nettype none
module ceoi_decode #(
	parameter int ID_BITS = 24
) (
	input  wire logic        wr_valid,
	input  wire logic [3:0]  wr_coproc,
	input  wire logic [2:0]  wr_opc1,
	input  wire logic [3:0]  wr_crn,
	input  wire logic [3:0]  wr_crm,
	input  wire logic [2:0]  wr_opc2,
	input  wire logic [31:0] wr_data,
	ceoi_req_if.dec          req
);
	// the slice below only fits the two documented identifier widths
	if (ID_BITS != ceoi_pkg::ID_W_FULL && ID_BITS != ceoi_pkg::ID_W_SHORT)
	begin : g_bad_id_bits
		$error("ID_BITS must be 16 or 24");
	end

	logic hit;
	always_comb
	begin
		hit = wr_valid && wr_coproc == ceoi_pkg::CP_COPROC && wr_opc1 == ceoi_pkg::CP_OPC1
			&& wr_crn == ceoi_pkg::CP_CRN && wr_opc2 == ceoi_pkg::OPC2_WRITE;
		req.tgt = ceoi_pkg::CEOI_TGT_NONE;
		if (hit)
		begin
			unique case (wr_crm)
				ceoi_pkg::CRM_DEACT: req.tgt = ceoi_pkg::CEOI_TGT_DEACT;
				ceoi_pkg::CRM_EOI0:  req.tgt = ceoi_pkg::CEOI_TGT_EOI0;
				ceoi_pkg::CRM_EOI1:  req.tgt = ceoi_pkg::CEOI_TGT_EOI1;
				default:             req.tgt = ceoi_pkg::CEOI_TGT_NONE;
			endcase
		end
		req.valid = req.tgt != ceoi_pkg::CEOI_TGT_NONE;
		req.interrupt_identifier = 24'h000000;
		req.interrupt_identifier[ID_BITS-1:0] = wr_data[ceoi_pkg::ID_LSB +: ID_BITS];
	end
endmodule : ceoi_decode
`default_nettype wire

// [core/ceoi_core.sv]
`timescale 1ns/1ns
`default_nettype none
module ceoi_core #(
	parameter int  ID_BITS      = 24,
	parameter bit  HAS_EL3      = 1'h1,
	parameter bit  EL3_IS_32BIT = 1'h1
) (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        clk_en,
	// processor write port
	input  wire logic        wr_valid,
	input  wire logic [3:0]  wr_coproc,
	input  wire logic [2:0]  wr_opc1,
	input  wire logic [3:0]  wr_crn,
	input  wire logic [3:0]  wr_crm,
	input  wire logic [2:0]  wr_opc2,
	input  wire logic [31:0] wr_data,
	// processor state
	input  wire logic [1:0]  cur_el,
	input  wire logic        cur_secure,
	input  wire logic        cur_monitor,
	// control bits
	input  wire logic        split_mode_ctl,
	input  wire logic        split_mode_secure,
	input  wire logic        split_mode_nonsecure,
	input  wire logic        monitor_split_mode_bit,
	input  wire logic        hyp_fast_irq_routing,
	input  wire logic        hyp_normal_irq_routing,
	input  wire logic        hyp_trap_all_group0,
	input  wire logic        hyp_trap_all_group1,
	input  wire logic        hyp_cp_group12_trap,
	input  wire logic        sysreg_interface_enable,
	input  wire logic        monitor_fast_irq_routing,
	input  wire logic        monitor_normal_irq_routing,
	// group of the identifier, answered by the distributor from interrupt_identifier_lookup
	output logic [23:0]      interrupt_identifier_lookup,
	input  wire logic        interrupt_identifier_is_group1,
	// results
	output logic             prio_drop_r,
	output logic             deactivate_r,
	output logic             virt_fwd_r,
	output logic [1:0]       virt_tgt_r,
	output logic             trap_el2_r,
	output logic             trap_el3_r,
	output logic             undef_r,
	output logic             sys_error_r,
	output logic [23:0]      interrupt_identifier_out_r,
	output logic             req_group1_r
);
	// only the two documented identifier widths are decoded
	if (ID_BITS != ceoi_pkg::ID_W_FULL && ID_BITS != ceoi_pkg::ID_W_SHORT)
	begin : g_bad_id_bits
		$error("ID_BITS must be 16 or 24");
	end

	ceoi_req_if req ();

	ceoi_decode #(.ID_BITS(ID_BITS)) u_dec (
		.wr_valid  (wr_valid),
		.wr_coproc (wr_coproc),
		.wr_opc1   (wr_opc1),
		.wr_crn    (wr_crn),
		.wr_crm    (wr_crm),
		.wr_opc2   (wr_opc2),
		.wr_data   (wr_data),
		.req       (req)
	);

	assign interrupt_identifier_lookup = req.interrupt_identifier;

	typedef struct packed {
		logic        prio_drop;
		logic        deactivate;
		logic        virt_fwd;
		logic [1:0]  virt_tgt;
		logic        trap_el2;
		logic        trap_el3;
		logic        undef;
		logic        sys_error;
		logic [23:0] interrupt_identifier;
		logic        group1;
	} ceoi_state_t;

	ceoi_state_t st_r;
	ceoi_state_t st_nxt;

	// ----------------------------------------------------------------
	// classification helpers
	// ----------------------------------------------------------------
	function automatic logic split_mode_sel(input logic mon, input logic sec);
		if (!HAS_EL3)
			return split_mode_ctl;
		else if (mon)
			return monitor_split_mode_bit;
		else if (sec)
			return split_mode_secure;
		else
			return split_mode_nonsecure;
	endfunction : split_mode_sel

	logic            is_ns_el1;
	logic            grp1;
	logic            grp_hyp_route;
	logic            grp_mon_route;
	logic            grp_trap_all;
	logic            split;
	ceoi_pkg::ceoi_out_t outcome;

	// ----------------------------------------------------------------
	// trap, undefined and redirect checks
	// ----------------------------------------------------------------
	always_comb
	begin
		is_ns_el1 = cur_el == ceoi_pkg::EL_1 && !cur_secure;
		// end registers name their group; deactivate asks the distributor
		grp1 = req.tgt == ceoi_pkg::CEOI_TGT_EOI1
			|| (req.tgt == ceoi_pkg::CEOI_TGT_DEACT && interrupt_identifier_is_group1);
		grp_hyp_route = grp1 ? hyp_normal_irq_routing : hyp_fast_irq_routing;
		grp_mon_route = grp1 ? monitor_normal_irq_routing : monitor_fast_irq_routing;
		grp_trap_all  = grp1 ? hyp_trap_all_group1 : hyp_trap_all_group0;
		split = split_mode_sel(cur_monitor, cur_secure);
		outcome = ceoi_pkg::CEOI_OUT_DONE;
		if (cur_el == ceoi_pkg::EL_0)
			outcome = ceoi_pkg::CEOI_OUT_UNDEF;
		else if (cur_el == ceoi_pkg::EL_1 && !sysreg_interface_enable)
			outcome = ceoi_pkg::CEOI_OUT_UNDEF;
		else if (HAS_EL3 && EL3_IS_32BIT && grp_mon_route
			&& (cur_el == ceoi_pkg::EL_2 || (cur_el == ceoi_pkg::EL_3 && !cur_monitor)))
			outcome = ceoi_pkg::CEOI_OUT_UNDEF;
		else if (is_ns_el1 && hyp_cp_group12_trap)
			outcome = ceoi_pkg::CEOI_OUT_TRAP2;
		else if (is_ns_el1 && req.tgt != ceoi_pkg::CEOI_TGT_DEACT && grp_trap_all)
			outcome = ceoi_pkg::CEOI_OUT_TRAP2;
		else if (HAS_EL3 && !EL3_IS_32BIT && grp_mon_route
			&& ((cur_el == ceoi_pkg::EL_1 && cur_secure) || cur_el == ceoi_pkg::EL_2))
			outcome = ceoi_pkg::CEOI_OUT_TRAP3;
		else if (is_ns_el1 && grp_hyp_route)
			outcome = ceoi_pkg::CEOI_OUT_VIRT;
		else if (req.tgt == ceoi_pkg::CEOI_TGT_DEACT && !split)
			outcome = ceoi_pkg::CEOI_OUT_IGN;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		st_nxt = '0;
		st_nxt.interrupt_identifier = st_r.interrupt_identifier;
		st_nxt.group1 = st_r.group1;
		if (req.valid)
		begin
			st_nxt.interrupt_identifier = req.interrupt_identifier;
			st_nxt.group1 = grp1;
			unique case (outcome)
				ceoi_pkg::CEOI_OUT_DONE:
				begin
					if (req.tgt == ceoi_pkg::CEOI_TGT_DEACT)
					begin
						st_nxt.deactivate = 1'h1;
					end
					else
					begin
						st_nxt.prio_drop = 1'h1;
						st_nxt.deactivate = !split;
					end
				end
				ceoi_pkg::CEOI_OUT_VIRT:
				begin
					st_nxt.virt_fwd = 1'h1;
					st_nxt.virt_tgt = req.tgt[1:0];
				end
				ceoi_pkg::CEOI_OUT_TRAP2: st_nxt.trap_el2 = 1'h1;
				ceoi_pkg::CEOI_OUT_TRAP3: st_nxt.trap_el3 = 1'h1;
				ceoi_pkg::CEOI_OUT_UNDEF: st_nxt.undef = 1'h1;
				ceoi_pkg::CEOI_OUT_IGN:   st_nxt.sys_error = 1'h1;
				default:                  st_nxt.undef = 1'h1;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			st_r <= '0;
		else if (clk_en)
			st_r <= st_nxt;
	end

	assign prio_drop_r  = st_r.prio_drop;
	assign deactivate_r = st_r.deactivate;
	assign virt_fwd_r   = st_r.virt_fwd;
	assign virt_tgt_r   = st_r.virt_tgt;
	assign trap_el2_r   = st_r.trap_el2;
	assign trap_el3_r   = st_r.trap_el3;
	assign undef_r      = st_r.undef;
	assign sys_error_r  = st_r.sys_error;
	assign interrupt_identifier_out_r  = st_r.interrupt_identifier;
	assign req_group1_r = st_r.group1;
endmodule : ceoi_core
`default_nettype wire

// [dv/ceoi_dist_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ----
// distributor group lookup
// ----
module ceoi_dist_model (
	input  wire logic [23:0] interrupt_identifier_lookup,
	output logic             interrupt_identifier_is_group1
);
	// odd identifiers sit in group 1; answer is combinational
	assign interrupt_identifier_is_group1 = interrupt_identifier_lookup[0];
endmodule : ceoi_dist_model
`default_nettype wire

// [dv/ceoi_core_props.sv]
`timescale 1ns/1ns
`default_nettype none
module ceoi_core_props #(
	parameter int ID_BITS = 24
) (
	input wire logic        mclk,
	input wire logic        rst_b,
	input wire logic        clk_en,
	input wire logic        wr_valid,
	input wire logic [3:0]  wr_coproc,
	input wire logic [2:0]  wr_opc1,
	input wire logic [3:0]  wr_crn,
	input wire logic [3:0]  wr_crm,
	input wire logic [2:0]  wr_opc2,
	input wire logic [31:0] wr_data,
	input wire logic [1:0]  cur_el,
	input wire logic        cur_secure,
	input wire logic        split_mode_nonsecure,
	input wire logic        hyp_cp_group12_trap,
	input wire logic        sysreg_interface_enable,
	input wire logic        monitor_fast_irq_routing,
	input wire logic        prio_drop_r,
	input wire logic        deactivate_r,
	input wire logic        virt_fwd_r,
	input wire logic        trap_el2_r,
	input wire logic        undef_r,
	input wire logic [23:0] interrupt_identifier_out_r
);
	localparam logic [23:0] IDM = (ID_BITS == 16) ? 24'h00ffff : 24'hffffff;
	wire t = wr_valid && clk_en && wr_coproc == 4'hf && wr_opc1 == 3'h0 && wr_crn == 4'hc
		&& wr_opc2 == 3'h1 && (wr_crm == 4'hb || wr_crm == 4'h8 || wr_crm == 4'hc);
	wire any = prio_drop_r || deactivate_r || virt_fwd_r || trap_el2_r || undef_r;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	AST_NO_HIT: assert property (clk_en && !t |=> !any)
		else $error("result without a decoded write");
	AST_DIR_NO_DROP: assert property (t && wr_crm == 4'hb |=> !prio_drop_r)
		else $error("deactivate write dropped priority");
	AST_EL0: assert property (t && cur_el == 2'h0 |=> undef_r && !prio_drop_r)
		else $error("EL0 write not undefined");
	AST_SRE: assert property (t && cur_el == 2'h1 && !sysreg_interface_enable |=> undef_r)
		else $error("disabled interface write not undefined");
	AST_GRP12: assert property (t && cur_el == 2'h1 && !cur_secure && sysreg_interface_enable
		&& hyp_cp_group12_trap |=> trap_el2_r && !undef_r)
		else $error("group 12 trap missing");
	AST_SPLIT0: assert property (t && wr_crm == 4'h8 && cur_el == 2'h2 && !cur_secure
		&& !split_mode_nonsecure && !monitor_fast_irq_routing |=> prio_drop_r && deactivate_r)
		else $error("end write in mode zero not drop and deactivate");
	AST_ID: assert property (t |=> interrupt_identifier_out_r == ($past(wr_data[23:0]) & IDM))
		else $error("identifier not masked to implemented width");
	AST_EXCL: assert property (trap_el2_r || undef_r |-> !prio_drop_r && !deactivate_r
		&& !virt_fwd_r)
		else $error("request forwarded despite trap");
	cover property (t && wr_crm == 4'hb ##1 deactivate_r);
	cover property (trap_el2_r);
	cover property (virt_fwd_r);
endmodule : ceoi_core_props
bind ceoi_core ceoi_core_props #(.ID_BITS(ID_BITS)) u_ceoi_core_props (.mclk, .rst_b,
	.clk_en, .wr_valid, .wr_coproc, .wr_opc1, .wr_crn, .wr_crm, .wr_opc2, .wr_data, .cur_el,
	.cur_secure, .split_mode_nonsecure, .hyp_cp_group12_trap, .sysreg_interface_enable,
	.monitor_fast_irq_routing, .prio_drop_r, .deactivate_r, .virt_fwd_r, .trap_el2_r,
	.undef_r, .interrupt_identifier_out_r);
`default_nettype wire

// [dv/cpu_if_eoi_deactivate_bench.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module cpu_if_eoi_deactivate_bench;
	logic        mclk = 0, rst_b = 0, clk_en = 1, wr_valid = 0, cur_secure = 0, cur_monitor = 0;
	logic [3:0]  wr_coproc = 4'hf, wr_crn = 4'hc, wr_crm = 4'h0;
	logic [2:0]  wr_opc1 = 3'h0, wr_opc2 = 3'h1;
	logic [31:0] wr_data = 32'h0;
	logic [1:0]  cur_el = 2'h0, virt_tgt_r;
	logic        split_mode_ctl = 0, split_mode_secure = 0, split_mode_nonsecure = 0;
	logic        monitor_split_mode_bit = 0, hyp_fast_irq_routing = 0, hyp_normal_irq_routing = 0;
	logic        hyp_trap_all_group0 = 0, hyp_trap_all_group1 = 0, hyp_cp_group12_trap = 0;
	logic        sysreg_interface_enable = 1, monitor_fast_irq_routing = 0;
	logic        monitor_normal_irq_routing = 0, interrupt_identifier_is_group1, prio_drop_r, deactivate_r;
	logic        virt_fwd_r, trap_el2_r, trap_el3_r, undef_r, sys_error_r, req_group1_r;
	logic [23:0] interrupt_identifier_lookup, interrupt_identifier_out_r;
	int          failures = 0, checks_done = 0, cyc = 0;
	wire [6:0]   pulses = {prio_drop_r, deactivate_r, virt_fwd_r, trap_el2_r, trap_el3_r,
		undef_r, sys_error_r};
	always #5 mclk = ~mclk;
	ceoi_core u_ceoi_core (.mclk, .rst_b, .clk_en, .wr_valid, .wr_coproc, .wr_opc1, .wr_crn,
		.wr_crm, .wr_opc2, .wr_data, .cur_el, .cur_secure, .cur_monitor, .split_mode_ctl,
		.split_mode_secure, .split_mode_nonsecure, .monitor_split_mode_bit,
		.hyp_fast_irq_routing, .hyp_normal_irq_routing, .hyp_trap_all_group0,
		.hyp_trap_all_group1, .hyp_cp_group12_trap, .sysreg_interface_enable,
		.monitor_fast_irq_routing, .monitor_normal_irq_routing, .interrupt_identifier_lookup,
		.interrupt_identifier_is_group1, .prio_drop_r, .deactivate_r, .virt_fwd_r, .virt_tgt_r, .trap_el2_r,
		.trap_el3_r, .undef_r, .sys_error_r, .interrupt_identifier_out_r, .req_group1_r);
	ceoi_dist_model u_ceoi_dist_model (.interrupt_identifier_lookup, .interrupt_identifier_is_group1);
	task automatic wrap_up;
		if (failures == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	// one write, result pulses compared as drop,deact,virt,el2,el3,undef,syserr
	task automatic wr(input logic [3:0] crm, input logic [1:0] el, input logic sec,
		input logic [31:0] d, input logic [6:0] e);
		@(posedge mclk);
		#1 {wr_crm, cur_el, cur_secure, wr_data, wr_valid} = {crm, el, sec, d, 1'b1};
		@(posedge mclk);
		#1 wr_valid = 0;
		`CHK("pulses", e, pulses)
	endtask : wr
	// hang guard: the sequence needs well under 200 cycles
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			failures++;
			wrap_up();
		end
	end
	initial
	begin
		repeat (20) @(posedge mclk);
		#1 rst_b = 1;
		wr(4'h8, 2'h2, 0, 32'hff000005, 7'h60);
		`CHK("interrupt_identifier", 24'h000005, interrupt_identifier_out_r)
		`CHK("group", 1'h0, req_group1_r)
		split_mode_nonsecure = 1;
		wr(4'hc, 2'h2, 0, 32'h7, 7'h40);
		wr(4'hb, 2'h2, 0, 32'h9, 7'h20);
		`CHK("group", 1'h1, req_group1_r)
		split_mode_nonsecure = 0;
		wr(4'hb, 2'h2, 0, 32'h9, 7'h01);
		split_mode_secure = 1;
		wr(4'h8, 2'h1, 1, 32'h3, 7'h40);
		{split_mode_secure, cur_monitor, monitor_split_mode_bit} = 3'b011;
		wr(4'h8, 2'h3, 1, 32'h3, 7'h40);
		{cur_monitor, hyp_fast_irq_routing} = 2'b01;
		wr(4'h8, 2'h1, 0, 32'h4, 7'h10);
		`CHK("tgt", 2'h2, virt_tgt_r)
		{hyp_fast_irq_routing, hyp_normal_irq_routing} = 2'b01;
		wr(4'hc, 2'h1, 0, 32'h4, 7'h10);
		`CHK("tgt", 2'h3, virt_tgt_r)
		wr(4'hb, 2'h1, 0, 32'h3, 7'h10);
		`CHK("tgt", 2'h1, virt_tgt_r)
		wr(4'hb, 2'h1, 0, 32'h2, 7'h01);
		{hyp_normal_irq_routing, hyp_trap_all_group0} = 2'b01;
		wr(4'h8, 2'h1, 0, 32'h4, 7'h08);
		wr(4'hc, 2'h1, 0, 32'h4, 7'h60);
		{hyp_trap_all_group0, hyp_cp_group12_trap} = 2'b01;
		wr(4'hb, 2'h1, 0, 32'h2, 7'h08);
		{hyp_cp_group12_trap, sysreg_interface_enable} = 2'b00;
		wr(4'h8, 2'h1, 1, 32'h2, 7'h02);
		sysreg_interface_enable = 1;
		wr(4'h8, 2'h0, 0, 32'h2, 7'h02);
		monitor_fast_irq_routing = 1;
		wr(4'h8, 2'h2, 0, 32'h2, 7'h02);
		wr(4'hc, 2'h2, 0, 32'h2, 7'h60);
		{monitor_fast_irq_routing, wr_opc2} = {1'b0, 3'h2};
		wr(4'h8, 2'h2, 0, 32'h2, 7'h00);
		wr_opc2 = 3'h1;
		wr(4'h8, 2'h2, 0, 32'h6, 7'h60);
		clk_en = 0;
		@(posedge mclk);
		#1;
		`CHK("frozen", 7'h60, pulses)
		`CHK("frozen id", 24'h000006, interrupt_identifier_out_r)
		{clk_en, rst_b} = 2'h2;
		@(posedge mclk);
		#1 rst_b = 1;
		`CHK("reset", 7'h00, pulses)
		`CHK("reset id", 24'h000000, interrupt_identifier_out_r)
		wr(4'h8, 2'h2, 0, 32'h1, 7'h60);
		wrap_up();
	end
endmodule : cpu_if_eoi_deactivate_bench
`default_nettype wire
